// [logic/esb_regs.sv]
// E1 spare-bit multiframe register bank: host registers, receive capture, transmit insertion

module esb_regs
  import esb_pkg::*;
(
  // Clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_srst,
  // Host register port
  input  wire logic [7:0]              i_host_addr,
  input  wire logic                    i_host_wr,
  input  wire logic                    i_host_rd,
  input  wire logic [7:0]              i_host_wdata,
  output logic      [7:0]              o_host_rdata,
  output logic                         o_host_rvalid,
  // Receive framer overhead
  input  wire logic                    i_rx_mf_flag,
  input  wire logic                    i_rx_frame_stb,
  input  wire logic [3:0]              i_rx_frame_num,
  input  wire logic [ESB_RX_LANES-1:0] i_rx_spare,
  // Transmit framer overhead
  input  wire logic                    i_tx_mf_flag,
  input  wire logic                    i_tx_frame_stb,
  input  wire logic [3:0]              i_tx_frame_num,
  input  wire logic                    i_tx_norm_intl,
  input  wire logic                    i_tx_norm_alarm,
  input  wire logic [ESB_TX_LANES-1:0] i_tx_norm_spare,
  // Transmit overhead bits to the framer
  output logic                         o_tx_valid,
  output logic                         o_tx_intl,
  output logic                         o_tx_alarm,
  output logic      [ESB_TX_LANES-1:0] o_tx_spare
);

  // Receive capture
  // The four receive registers live in the capture block; this module
  // only routes the framer strobes in and the published bytes out.
  // Capture runs per frame, publishing waits for the multiframe flag, so a
  // host read never sees half of one multiframe and half of the next.

  // Carrier to the capture block
  esb_rx_if rx_bus ();

  // Framer inputs go straight to the capture block
  // They are synchronous to the clock already, so no resync stage is needed
  assign rx_bus.mf_flag   = i_rx_mf_flag;
  assign rx_bus.frame_stb = i_rx_frame_stb;
  assign rx_bus.frame_num = i_rx_frame_num;
  assign rx_bus.spare     = i_rx_spare;

  // Capture block owns the four read-only receive registers
  esb_rx_capture u_rx_capture
  (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .rx        (rx_bus)
  );

  // Host-writable transmit registers
  // A write lands on the edge that samples the strobe; there are no wait
  // states, so back-to-back writes on consecutive cycles are accepted.
  // No chip select is decoded: an offset outside the map is simply not
  // written, which keeps the port a plain strobe interface.

  // Host copies; the transmit path sees the data bytes through the sample or its flag bypass, the control byte directly
  esb_byte_t tx_intl_even_frames_reg;   // Even-frame Si source
  esb_byte_t tx_intl_odd_frames_reg;    // Odd-frame Si source
  esb_byte_t tx_far_alarm_frames_reg;   // Remote alarm source
  esb_byte_t tx_spare4_frames_reg;      // Sa4 source
  esb_byte_t tx_spare5_frames_reg;      // Sa5 source
  esb_byte_t tx_spare6_frames_reg;      // Sa6 source
  esb_byte_t tx_spare7_frames_reg;      // Sa7 source
  esb_byte_t tx_spare8_frames_reg;      // Sa8 source
  esb_byte_t tx_overhead_insert_ctrl_reg; // Insertion enables

  // Named views of the insertion enables
  logic                    insert_intl_even_en;   // Even-frame Si enable
  logic                    insert_intl_odd_en;    // Odd-frame Si enable
  logic                    insert_far_alarm_en;   // Remote alarm enable
  logic [ESB_TX_LANES-1:0] insert_spare_en;       // Sa4..Sa8 enables, Sa4 in MSB

  // Decode of a host write to one offset
  // Shared by the write decoders so every register decodes the same way
  function automatic logic host_hit(input logic [7:0] addr, input esb_byte_t ofs);
    host_hit = (addr == ofs);
  endfunction

  // Transmit data registers: plain storage, written by the host only
  // Reset clears them; with all enables clear nothing reaches the line
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      tx_intl_even_frames_reg <= ESB_REG_RESET;
      tx_intl_odd_frames_reg  <= ESB_REG_RESET;
      tx_far_alarm_frames_reg <= ESB_REG_RESET;
      tx_spare4_frames_reg    <= ESB_REG_RESET;
      tx_spare5_frames_reg    <= ESB_REG_RESET;
      tx_spare6_frames_reg    <= ESB_REG_RESET;
      tx_spare7_frames_reg    <= ESB_REG_RESET;
      tx_spare8_frames_reg    <= ESB_REG_RESET;
    end
    else if (i_host_wr)
    begin
      // Writes to read-only or unmapped offsets fall through silently
      if (host_hit(i_host_addr, ESB_TX_INTL_EVEN_OFS))
        tx_intl_even_frames_reg <= i_host_wdata;
      if (host_hit(i_host_addr, ESB_TX_INTL_ODD_OFS))
        tx_intl_odd_frames_reg <= i_host_wdata;
      if (host_hit(i_host_addr, ESB_TX_ALARM_OFS))
        tx_far_alarm_frames_reg <= i_host_wdata;
      if (host_hit(i_host_addr, ESB_TX_SPARE4_OFS))
        tx_spare4_frames_reg <= i_host_wdata;
      if (host_hit(i_host_addr, ESB_TX_SPARE5_OFS))
        tx_spare5_frames_reg <= i_host_wdata;
      if (host_hit(i_host_addr, ESB_TX_SPARE6_OFS))
        tx_spare6_frames_reg <= i_host_wdata;
      if (host_hit(i_host_addr, ESB_TX_SPARE7_OFS))
        tx_spare7_frames_reg <= i_host_wdata;
      if (host_hit(i_host_addr, ESB_TX_SPARE8_OFS))
        tx_spare8_frames_reg <= i_host_wdata;
    end
  end

  // Insertion control: acts at once, not held to multiframe boundaries
  // A change applies to the very next frame request; software wanting a
  // clean switch should write it just before the transmit flag
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      tx_overhead_insert_ctrl_reg <= ESB_REG_RESET;
    else if (i_host_wr && host_hit(i_host_addr, ESB_TX_CTRL_OFS))
      tx_overhead_insert_ctrl_reg <= i_host_wdata;
  end

  // Split the control byte into its enables
  assign insert_intl_even_en = tx_overhead_insert_ctrl_reg[ESB_CTRL_INTL_EVEN_BIT];
  assign insert_intl_odd_en  = tx_overhead_insert_ctrl_reg[ESB_CTRL_INTL_ODD_BIT];
  assign insert_far_alarm_en = tx_overhead_insert_ctrl_reg[ESB_CTRL_ALARM_BIT];
  assign insert_spare_en     =
    tx_overhead_insert_ctrl_reg[ESB_CTRL_SPARE4_BIT -: ESB_TX_LANES];

  // Host read path
  // Read data comes from a register so the port output is glitch free;
  // the cost is one cycle of latency, flagged by the read-valid pulse.
  // A read in the same cycle as a write to that offset returns the old
  // byte, because the mux looks at the register before the write edge.

  esb_byte_t host_rdata_next; // Read mux output

  // Read mux; unmapped offsets answer zero
  // The gaps inside the map answer zero too, never a stale byte
  always_comb
  begin
    unique case (i_host_addr)
      ESB_RX_SPARE5_OFS:    host_rdata_next = rx_bus.frames[0];
      ESB_RX_SPARE6_OFS:    host_rdata_next = rx_bus.frames[1];
      ESB_RX_SPARE7_OFS:    host_rdata_next = rx_bus.frames[2];
      ESB_RX_SPARE8_OFS:    host_rdata_next = rx_bus.frames[3];
      ESB_TX_INTL_EVEN_OFS: host_rdata_next = tx_intl_even_frames_reg;
      ESB_TX_INTL_ODD_OFS:  host_rdata_next = tx_intl_odd_frames_reg;
      ESB_TX_ALARM_OFS:     host_rdata_next = tx_far_alarm_frames_reg;
      ESB_TX_SPARE4_OFS:    host_rdata_next = tx_spare4_frames_reg;
      ESB_TX_SPARE5_OFS:    host_rdata_next = tx_spare5_frames_reg;
      ESB_TX_SPARE6_OFS:    host_rdata_next = tx_spare6_frames_reg;
      ESB_TX_SPARE7_OFS:    host_rdata_next = tx_spare7_frames_reg;
      ESB_TX_SPARE8_OFS:    host_rdata_next = tx_spare8_frames_reg;
      ESB_TX_CTRL_OFS:      host_rdata_next = tx_overhead_insert_ctrl_reg;
      default:              host_rdata_next = ESB_UNMAPPED_DATA;
    endcase
  end

  // Read data register: held between reads so the host may sample late
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_host_rdata <= ESB_REG_RESET;
    else if (i_host_rd)
      o_host_rdata <= host_rdata_next;
  end

  // Read strobe: one cycle after each accepted read
  // Every read is answered, mapped or not, so the host never stalls
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_host_rvalid <= 1'b0;
    else
      o_host_rvalid <= i_host_rd;
  end

  // Transmit multiframe sample
  // The host has one multiframe after the flag to refresh the sources;
  // if it misses that window the previous pattern simply repeats.

  // Working copies used for the running multiframe; a host write mid-frame
  // cannot tear the pattern, it waits for the next multiframe
  esb_byte_t                    work_intl_even_reg;
  esb_byte_t                    work_intl_odd_reg;
  esb_byte_t                    work_alarm_reg;
  logic [ESB_TX_LANES-1:0][7:0] work_spare_reg;   // Lane 0 = Sa4

  // Source set for the current frame: the new sample wins on a flag cycle
  esb_byte_t                    src_intl_even;
  esb_byte_t                    src_intl_odd;
  esb_byte_t                    src_alarm;
  logic [ESB_TX_LANES-1:0][7:0] src_spare;
  logic [ESB_TX_LANES-1:0][7:0] live_spare;       // Host registers packed

  // Host registers as lanes: Sa8 lands in the top lane, Sa4 in lane 0
  assign live_spare = {tx_spare8_frames_reg, tx_spare7_frames_reg,
                       tx_spare6_frames_reg, tx_spare5_frames_reg,
                       tx_spare4_frames_reg};

  // Sample on the transmit multiframe flag; otherwise hold so old data repeats
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      work_intl_even_reg <= ESB_REG_RESET;
      work_intl_odd_reg  <= ESB_REG_RESET;
      work_alarm_reg     <= ESB_REG_RESET;
      work_spare_reg     <= {ESB_TX_LANES{ESB_REG_RESET}};
    end
    else if (i_tx_mf_flag)
    begin
      work_intl_even_reg <= tx_intl_even_frames_reg;
      work_intl_odd_reg  <= tx_intl_odd_frames_reg;
      work_alarm_reg     <= tx_far_alarm_frames_reg;
      work_spare_reg     <= live_spare;
    end
  end

  // Frame zero of a multiframe coincides with the flag, so use live values
  // Without this bypass frame 0 would go out from the previous sample
  always_comb
  begin
    if (i_tx_mf_flag)
    begin
      src_intl_even = tx_intl_even_frames_reg;
      src_intl_odd  = tx_intl_odd_frames_reg;
      src_alarm     = tx_far_alarm_frames_reg;
      src_spare     = live_spare;
    end
    else
    begin
      src_intl_even = work_intl_even_reg;
      src_intl_odd  = work_intl_odd_reg;
      src_alarm     = work_alarm_reg;
      src_spare     = work_spare_reg;
    end
  end

  // Transmit insertion
  // Each request picks one bit per source at the frame's register bit;
  // even frames carry the alignment word, so only Si is replaced there.

  logic                    tx_intl_next;   // Si bit for this frame
  logic                    tx_alarm_next;  // A bit for this frame
  logic [ESB_TX_LANES-1:0] tx_spare_next;  // Sa4..Sa8 for this frame
  logic [2:0]              tx_pos;         // Register bit for this frame

  // Frame 0 or 1 maps to bit 7, so the MSB leaves first
  assign tx_pos = esb_frame_pos(i_tx_frame_num);

  // Per-frame selection between register and framer's own bit
  always_comb
  begin
    // Framer's normal source unless a register is inserted
    tx_intl_next  = i_tx_norm_intl;
    tx_alarm_next = i_tx_norm_alarm;
    tx_spare_next = i_tx_norm_spare;
    if (!i_tx_frame_num[0])
    begin
      // Alignment frame: only Si is spare, the rest is the alignment word
      if (insert_intl_even_en)
        tx_intl_next = src_intl_even[tx_pos];
    end
    else
    begin
      // Nonalignment frame: Si, A and Sa4..Sa8 all insertable
      if (insert_intl_odd_en)
        tx_intl_next = src_intl_odd[tx_pos];
      if (insert_far_alarm_en)
        tx_alarm_next = src_alarm[tx_pos];
      // Lane i is Sa4+i; its enable and output bit sit at the mirrored place
      for (int i = 0; i < ESB_TX_LANES; i++)
      begin
        if (insert_spare_en[ESB_TX_LANES-1-i])
          tx_spare_next[ESB_TX_LANES-1-i] = src_spare[i][tx_pos];
      end
    end
  end

  // Output bits registered; held between frames for a slow framer
  // Reset drives zero so the framer sees a quiet overhead before setup
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_tx_intl  <= 1'b0;
      o_tx_alarm <= 1'b0;
      o_tx_spare <= '0;
    end
    else if (i_tx_frame_stb)
    begin
      o_tx_intl  <= tx_intl_next;
      o_tx_alarm <= tx_alarm_next;
      o_tx_spare <= tx_spare_next;
    end
  end

  // Output strobe: one cycle after each frame request
  // The framer may take the bits on this pulse or any time before the next
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_tx_valid <= 1'b0;
    else
      o_tx_valid <= i_tx_frame_stb;
  end

endmodule

// [logic/esb_pkg.sv]
// Shared constants and types for the E1 spare-bit multiframe register bank
package esb_pkg;

  // Register byte type of the 8-bit host port
  typedef logic [7:0] esb_byte_t;

  // Receive spare-bit register offsets (read only)
  localparam esb_byte_t ESB_RX_SPARE5_OFS   = 8'hCC;
  localparam esb_byte_t ESB_RX_SPARE6_OFS   = 8'hCD;
  localparam esb_byte_t ESB_RX_SPARE7_OFS   = 8'hCE;
  localparam esb_byte_t ESB_RX_SPARE8_OFS   = 8'hCF;

  // Transmit source register offsets (read/write)
  localparam esb_byte_t ESB_TX_INTL_EVEN_OFS = 8'hD2;
  localparam esb_byte_t ESB_TX_INTL_ODD_OFS  = 8'hD3;
  localparam esb_byte_t ESB_TX_ALARM_OFS     = 8'hD4;
  localparam esb_byte_t ESB_TX_SPARE4_OFS    = 8'hD5;
  localparam esb_byte_t ESB_TX_SPARE5_OFS    = 8'hD6;
  localparam esb_byte_t ESB_TX_SPARE6_OFS    = 8'hD7;
  localparam esb_byte_t ESB_TX_SPARE7_OFS    = 8'hD8;
  localparam esb_byte_t ESB_TX_SPARE8_OFS    = 8'hD9;
  localparam esb_byte_t ESB_TX_CTRL_OFS      = 8'hDA;

  // Value after reset of every register in the bank
  localparam esb_byte_t ESB_REG_RESET       = 8'h00;
  // Value returned for an unmapped read
  localparam esb_byte_t ESB_UNMAPPED_DATA   = 8'h00;

  // Insertion control field positions
  localparam int unsigned ESB_CTRL_INTL_EVEN_BIT = 7;
  localparam int unsigned ESB_CTRL_INTL_ODD_BIT  = 6;
  localparam int unsigned ESB_CTRL_ALARM_BIT     = 5;
  localparam int unsigned ESB_CTRL_SPARE4_BIT    = 4;

  // Number of spare-bit lanes: transmit Sa4..Sa8, receive Sa5..Sa8
  localparam int unsigned ESB_TX_LANES = 5;
  localparam int unsigned ESB_RX_LANES = 4;

  // Bit position in a register of a frame: lowest frame sits in the MSB
  function automatic logic [2:0] esb_frame_pos(input logic [3:0] frame_num);
    esb_frame_pos = 3'd7 - frame_num[3:1];
  endfunction

endpackage

// [logic/esb_rx_if.sv]
// Carrier between the register bank core and its receive capture block
interface esb_rx_if;
  import esb_pkg::*;

  logic                          mf_flag;    // Receive multiframe flag sets
  logic                          frame_stb;  // One frame's overhead bits valid
  logic [3:0]                    frame_num;  // Frame number inside multiframe
  logic [ESB_RX_LANES-1:0]       spare;      // Sa5..Sa8, Sa5 in the MSB
  logic [ESB_RX_LANES-1:0][7:0]  frames;     // Published registers, lane 0 = Sa5

  // Capture side
  modport cap
  (
    input  mf_flag,
    input  frame_stb,
    input  frame_num,
    input  spare,
    output frames
  );

  // Core side
  modport core
  (
    output mf_flag,
    output frame_stb,
    output frame_num,
    output spare,
    input  frames
  );
endinterface

// [logic/esb_rx_capture.sv]
// Receive capture of the odd-frame Sa5..Sa8 bits over one multiframe
module esb_rx_capture
  import esb_pkg::*;
(
  // Clock and reset
  input  wire logic   i_ref_clk,
  input  wire logic   i_srst,
  // Framer side and published registers
  esb_rx_if.cap       rx
);

  // Shadow gathered while the multiframe runs
  logic [ESB_RX_LANES-1:0][7:0] shadow_reg;
  // Shadow with the current frame merged, so a flag and a frame may coincide
  logic [ESB_RX_LANES-1:0][7:0] shadow_next;

  // Merge the odd frame's bits at the frame's position
  always_comb
  begin
    shadow_next = shadow_reg;
    if (rx.frame_stb && rx.frame_num[0])
    begin
      for (int i = 0; i < ESB_RX_LANES; i++)
      begin
        shadow_next[i][esb_frame_pos(rx.frame_num)] = rx.spare[ESB_RX_LANES-1-i];
      end
    end
  end

  // Shadow update each odd frame
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      shadow_reg <= '0;
    else
      shadow_reg <= shadow_next;
  end

  // Publish only on the multiframe flag; stale data holds until the next one
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      rx.frames <= {ESB_RX_LANES{ESB_REG_RESET}};
    else if (rx.mf_flag)
      rx.frames <= shadow_next;
  end

endmodule

// [verif/esb_regs_checker.sv]
// Concurrent checks on the host and transmit ports of the spare-bit register bank
module esb_regs_checker
  import esb_pkg::*;
(
  // Clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_srst,
  // Host register port
  input  wire logic [7:0]              i_host_addr,
  input  wire logic                    i_host_wr,
  input  wire logic                    i_host_rd,
  input  wire logic [7:0]              i_host_wdata,
  input  wire logic [7:0]              o_host_rdata,
  input  wire logic                    o_host_rvalid,
  // Transmit framer side
  input  wire logic                    i_tx_frame_stb,
  input  wire logic [3:0]              i_tx_frame_num,
  input  wire logic                    i_tx_norm_alarm,
  input  wire logic [ESB_TX_LANES-1:0] i_tx_norm_spare,
  input  wire logic                    o_tx_valid,
  input  wire logic                    o_tx_intl,
  input  wire logic                    o_tx_alarm,
  input  wire logic [ESB_TX_LANES-1:0] o_tx_spare
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);
  // Address decode mirrored from the register map
  logic rw_addr;  // Writable transmit and control registers
  logic mapped;   // Any register of the bank
  assign rw_addr = (i_host_addr >= ESB_TX_INTL_EVEN_OFS) && (i_host_addr <= ESB_TX_CTRL_OFS);
  assign mapped  = rw_addr || ((i_host_addr >= ESB_RX_SPARE5_OFS)
                   && (i_host_addr <= ESB_RX_SPARE8_OFS));
  // Clean write to a writable register
  sequence s_wr_rw;
    i_host_wr && !i_host_rd && rw_addr;
  endsequence
  // Clean read of the address written two cycles earlier
  sequence s_rd_back;
    i_host_rd && !i_host_wr && (i_host_addr == $past(i_host_addr, 2));
  endsequence
  // Host port: every read answered one cycle later, and only then
  chk_rvalid_follows: assert property (i_host_rd |=> o_host_rvalid)
    else $error("read strobe not answered");
  chk_rvalid_cause: assert property (o_host_rvalid |-> $past(i_host_rd))
    else $error("read answer without a read");
  // Read data is a register: it moves only on a read
  chk_rdata_holds: assert property (!i_host_rd |=> $stable(o_host_rdata))
    else $error("read data moved without a read");
  // Write, one idle cycle, read of that offset: the written byte returns
  chk_write_readback: assert property (s_wr_rw ##1 !i_host_wr ##1 s_rd_back
    |=> o_host_rdata == $past(i_host_wdata, 3)) else $error("written value not read back");
  chk_unmapped_zero: assert property (i_host_rd && !mapped
    |=> o_host_rdata == ESB_UNMAPPED_DATA) else $error("unmapped read not zero");
  // Transmit port: one answer per request, bits held in between
  chk_txvalid_follows: assert property (i_tx_frame_stb |=> o_tx_valid)
    else $error("transmit request not answered");
  chk_txvalid_cause: assert property (o_tx_valid |-> $past(i_tx_frame_stb))
    else $error("transmit valid without request");
  chk_tx_bits_hold: assert property (!i_tx_frame_stb |=> $stable(o_tx_intl)
    && $stable(o_tx_alarm) && $stable(o_tx_spare)) else $error("transmit bits moved");
  // Even frames never take A or Sa from the registers
  chk_even_normal: assert property (i_tx_frame_stb && !i_tx_frame_num[0]
    |=> o_tx_alarm == $past(i_tx_norm_alarm) && o_tx_spare == $past(i_tx_norm_spare))
    else $error("even frame alarm or spare not normal");
endmodule

bind esb_regs esb_regs_checker i_chk (.i_ref_clk, .i_srst, .i_host_addr, .i_host_wr,
  .i_host_rd, .i_host_wdata, .o_host_rdata, .o_host_rvalid, .i_tx_frame_stb, .i_tx_frame_num,
  .i_tx_norm_alarm, .i_tx_norm_spare, .o_tx_valid, .o_tx_intl, .o_tx_alarm, .o_tx_spare);

// [verif/esb_far_end.sv]
// Behavioural far end sending one receive multiframe of Sa5..Sa8 bits
module esb_far_end
(
  // Clock and start request
  input  wire logic        i_ref_clk,
  input  wire logic        i_go,
  input  wire logic [31:0] i_pat,
  // Receive overhead towards the block
  output logic             o_rx_mf_flag,
  output logic             o_rx_frame_stb,
  output logic [3:0]       o_rx_frame_num,
  output logic [3:0]       o_rx_spare,
  output logic             o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] bits;  // Sa5..Sa8 of the current frame
  logic [2:0] pos;   // Register bit the frame lands in
  initial
  begin
    {o_rx_mf_flag, o_rx_frame_stb, o_rx_frame_num, o_rx_spare, o_busy} = '0;
  end
  // Sixteen frames back to back, then the flag; even frames carry junk that must be dropped
  always
  begin
    @(posedge i_ref_clk);
    if (i_go)
    begin
      for (int n = 0; n < 16; n++)
      begin
        pos  = 3'd7 - 3'(n >> 1);
        bits = {i_pat[24 + pos], i_pat[16 + pos], i_pat[8 + pos], i_pat[pos]};
        #1;
        o_busy         = 1'b1;
        o_rx_frame_stb = 1'b1;
        o_rx_frame_num = 4'(n);
        o_rx_spare     = n[0] ? bits : ~bits;
        @(posedge i_ref_clk);
      end
      // Released lines show the inverse, so a stale value cannot pass for a capture
      #1;
      o_rx_frame_stb = 1'b0;
      o_rx_spare     = ~o_rx_spare;
      o_rx_mf_flag   = 1'b1;
      @(posedge i_ref_clk);
      #1;
      o_rx_mf_flag = 1'b0;
      o_busy       = 1'b0;
      wait (!i_go);
    end
  end
endmodule

// [verif/esb_regs_tb_top.sv]
// Self-checking bench of the spare-bit register bank
module esb_regs_tb_top
  import esb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TIMEOUT_CYC = 3000;  // Run needs well under a thousand cycles
  // Clock, reset and host port
  logic                    clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, rvalid;
  esb_byte_t               addr = '0, wdata = '0, rdata;
  // Receive side, driven by the far-end model
  logic                    rx_mf, rx_stb, go = 1'b0, busy;
  logic [3:0]              rx_num, rx_spare;
  logic [31:0]             pat = '0;
  // Transmit framer side
  logic                    tx_mf = 1'b0, tx_stb = 1'b0, n_intl = 1'b0, n_alarm = 1'b0;
  logic [3:0]              tx_num = '0;
  logic [ESB_TX_LANES-1:0] n_spare = '0, tx_spare;
  logic                    tx_valid, tx_intl, tx_alarm;
  // Host copy of the writable registers and the copy taken at the flag
  esb_byte_t               txr [9];
  esb_byte_t               sh [8];
  int                      error_cnt = 0, n_compared = 0, cyc = 0;

  always #2.5 clk = ~clk;

  esb_regs i_dut (.i_ref_clk(clk), .i_srst(srst), .i_host_addr(addr), .i_host_wr(wr),
    .i_host_rd(rd), .i_host_wdata(wdata), .o_host_rdata(rdata), .o_host_rvalid(rvalid),
    .i_rx_mf_flag(rx_mf), .i_rx_frame_stb(rx_stb), .i_rx_frame_num(rx_num),
    .i_rx_spare(rx_spare), .i_tx_mf_flag(tx_mf), .i_tx_frame_stb(tx_stb),
    .i_tx_frame_num(tx_num), .i_tx_norm_intl(n_intl), .i_tx_norm_alarm(n_alarm),
    .i_tx_norm_spare(n_spare), .o_tx_valid(tx_valid), .o_tx_intl(tx_intl),
    .o_tx_alarm(tx_alarm), .o_tx_spare(tx_spare));
  esb_far_end i_far (.i_ref_clk(clk), .i_go(go), .i_pat(pat), .o_rx_mf_flag(rx_mf),
    .o_rx_frame_stb(rx_stb), .o_rx_frame_num(rx_num), .o_rx_spare(rx_spare), .o_busy(busy));

  // Hang guard: a run past the ceiling counts as a mismatch
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT_CYC)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk8(input string what, input esb_byte_t exp, input esb_byte_t got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // One-cycle write strobe
  task automatic host_wr(input esb_byte_t a, input esb_byte_t d);
    @(posedge clk);
    #1;
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask

  // One-cycle read strobe; answer is looked at in the cycle it stands
  task automatic rd_chk(input esb_byte_t a, input esb_byte_t exp);
    @(posedge clk);
    #1;
    addr = a;
    rd   = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    chk1("rvalid", 1'b1, rvalid);
    chk8($sformatf("reg %h", a), exp, rdata);
  endtask

  // One transmit request; disabled sources and even-frame A/Sa come from the normal inputs
  task automatic tx_frame(input int n, input logic mf);
    logic [2:0]              pos;
    logic [ESB_TX_LANES-1:0] es;
    esb_byte_t               c;
    pos = 3'd7 - 3'(n >> 1);
    c   = txr[8];
    @(posedge clk);
    #1;
    tx_stb  = 1'b1;
    tx_num  = 4'(n);
    tx_mf   = mf;
    n_intl  = ~n[1];
    n_alarm = n[2];
    n_spare = 5'(n * 3) ^ 5'h15;
    if (mf)
      for (int i = 0; i < 8; i++)
        sh[i] = txr[i];
    for (int b = 0; b < 5; b++)
      es[b] = (n[0] && c[b]) ? sh[7 - b][pos] : n_spare[b];
    @(posedge clk);
    #1;
    tx_stb = 1'b0;
    tx_mf  = 1'b0;
    chk1("tx_valid", 1'b1, tx_valid);
    chk1("tx_intl", n[0] ? (c[6] ? sh[1][pos] : n_intl) : (c[7] ? sh[0][pos] : n_intl),
      tx_intl);
    chk1("tx_alarm", (n[0] && c[5]) ? sh[2][pos] : n_alarm, tx_alarm);
    chk8("tx_spare", {3'b000, es}, {3'b000, tx_spare});
  endtask

  task automatic conclude();
    $display("Checks: %0d compared, %0d mismatched", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    srst = 1'b0;
    // Every register of the bank comes out of reset clear
    for (int i = 0; i < 13; i++)
      rd_chk(i < 4 ? ESB_RX_SPARE5_OFS + 8'(i) : ESB_TX_INTL_EVEN_OFS + 8'(i - 4),
        ESB_REG_RESET);
    // Distinct values into D2h..DAh, read back newest first
    for (int i = 0; i < 9; i++)
    begin
      txr[i] = 8'hA5 ^ 8'(i * 29);
      host_wr(ESB_TX_INTL_EVEN_OFS + 8'(i), txr[i]);
    end
    for (int i = 8; i >= 0; i--)
      rd_chk(ESB_TX_INTL_EVEN_OFS + 8'(i), txr[i]);
    // Read-only and unmapped places refuse writes
    host_wr(ESB_RX_SPARE5_OFS, 8'hFF);
    rd_chk(ESB_RX_SPARE5_OFS, ESB_REG_RESET);
    host_wr(8'hDB, 8'hFF);
    rd_chk(8'hDB, ESB_UNMAPPED_DATA);
    rd_chk(8'hD0, ESB_UNMAPPED_DATA);
    // Two multiframes: the second capture must overwrite the first
    for (int p = 0; p < 2; p++)
    begin
      pat = p ? 32'h5A3C_E169 : 32'hA5C3_1E96;
      @(posedge clk);
      #1;
      go = 1'b1;
      @(negedge busy);
      go = 1'b0;
      for (int k = 0; k < 4; k++)
        rd_chk(ESB_RX_SPARE5_OFS + 8'(k), pat[31 - 8 * k -: 8]);
    end
    // Three control settings; a mid-multiframe write waits for the next flag, control does not
    for (int p = 0; p < 3; p++)
    begin
      txr[8] = (p == 0) ? 8'hFF : ((p == 1) ? 8'h00 : 8'hA6);
      host_wr(ESB_TX_CTRL_OFS, txr[8]);
      for (int n = 0; n < 16; n++)
      begin
        if (n == 8)
        begin
          txr[p * 4] = ~txr[p * 4];
          host_wr(ESB_TX_INTL_EVEN_OFS + 8'(p * 4), txr[p * 4]);
        end
        tx_frame(n, n == 0);
      end
    end
    conclude();
  end
endmodule
